// *** hdl/t1cs_top.sv ***
// Timer 1 control/status register with event flag, interrupt gate,
// external trigger and generate gating and the paired PWM output.
// Assumes datapath events arrive as one-cycle pulses on clk.
`timescale 1ns/1ns
module t1cs_top (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Register access port
    input  wire t1cs_pkg::t1cs_req_s   req,
    output logic [31:0]                rdata,
    output logic                       rvalid,
    // Datapath events, same clock
    input  wire logic                  t1_rollover,
    input  wire logic                  t0_rollover,
    input  wire logic                  gen_raw,
    input  wire logic                  capture_read,
    // External pins
    input  wire logic                  capture_trig,
    output logic                       gen_out,
    output logic                       pwm_out,
    // Controls toward the datapath and timer 0
    output t1cs_pkg::t1cs_ctrl_s       ctrl,
    output logic                       capture_store,
    output logic                       hold_at_terminal,
    output logic                       timer0_run_set,
    output logic                       irq
);

    // Register fields
    t1cs_pkg::t1cs_ctrl_s ctrl_q, ctrl_d;
    // Read data and its valid
    logic [31:0]          rdata_q, rdata_d;
    logic                 rvalid_q, rvalid_d;
    // Trigger synchroniser and edge history
    logic                 trig_s1_q, trig_s2_q, trig_prev_q;
    // Registered pins
    logic                 gen_q, gen_d;
    logic                 pwm_q, pwm_d;
    logic                 irq_q, irq_d;
    logic                 t0set_q, t0set_d;
    // A captured value not yet read back
    logic                 held_q, held_d;
    // Decoded strobes
    logic                 wr_hi, wr_lo, trig_edge, cap_fire, flag_set;

    // Register image for reads; reserved bits read as zero
    function automatic logic [31:0] image(input t1cs_pkg::t1cs_ctrl_s c);
        logic [31:0] w;
        w = t1cs_pkg::REG_RESET;
        w[t1cs_pkg::ALL_EN_BIT]   = c.all_timers_enable;
        w[t1cs_pkg::PWM_EN_BIT]   = c.pwm_pair_enable;
        w[t1cs_pkg::IRQ_FLAG_BIT] = c.timer1_irq_flag;
        w[t1cs_pkg::RUN_EN_BIT]   = c.timer1_run_enable;
        w[t1cs_pkg::IRQ_EN_BIT]   = c.timer1_irq_enable;
        w[t1cs_pkg::LOAD_BIT]     = c.timer1_load_strobe;
        w[t1cs_pkg::AUTO_RLD_BIT] = c.timer1_auto_reload;
        w[t1cs_pkg::EXT_CAP_BIT]  = c.timer1_ext_capture_enable;
        w[t1cs_pkg::EXT_GEN_BIT]  = c.timer1_ext_generate_enable;
        w[t1cs_pkg::DOWN_BIT]     = c.timer1_count_down;
        w[t1cs_pkg::CAP_MODE_BIT] = c.timer1_capture_mode;
        return w;
    endfunction : image

    // Lane decode of a write
    assign wr_hi = req.wr_en && req.be[t1cs_pkg::LANE_HI];
    assign wr_lo = req.wr_en && req.be[t1cs_pkg::LANE_LO];

    // Only the second stage is looked at by the edge detector
    assign trig_edge = trig_s2_q && !trig_prev_q;
    assign cap_fire  = trig_edge && ctrl_q.timer1_ext_capture_enable; // RULE_12

    // Flag sources: capture while running in capture mode, or rollover in generate mode
    assign flag_set =
        (cap_fire && ctrl_q.timer1_run_enable
                  && ctrl_q.timer1_capture_mode)                    // RULE_04
        || (t1_rollover && !ctrl_q.timer1_capture_mode);            // RULE_05

    // Next state of the register fields
    always_comb begin
        ctrl_d  = ctrl_q;
        t0set_d = 1'b0;
        if (wr_hi) begin
            ctrl_d.timer1_capture_mode  =
                req.wdata[t1cs_pkg::CAP_MODE_BIT];                  // RULE_15
            ctrl_d.timer1_count_down    =
                req.wdata[t1cs_pkg::DOWN_BIT];                      // RULE_14
            ctrl_d.timer1_ext_generate_enable =
                req.wdata[t1cs_pkg::EXT_GEN_BIT];
            ctrl_d.timer1_ext_capture_enable  =
                req.wdata[t1cs_pkg::EXT_CAP_BIT];
            ctrl_d.timer1_auto_reload   = req.wdata[t1cs_pkg::AUTO_RLD_BIT];
            ctrl_d.timer1_load_strobe   = req.wdata[t1cs_pkg::LOAD_BIT];
            ctrl_d.timer1_irq_enable    = req.wdata[t1cs_pkg::IRQ_EN_BIT];
            ctrl_d.timer1_run_enable    =
                req.wdata[t1cs_pkg::RUN_EN_BIT];                    // RULE_07
        end
        if (wr_lo) begin
            ctrl_d.pwm_pair_enable   =
                req.wdata[t1cs_pkg::PWM_EN_BIT];                    // RULE_01
            ctrl_d.all_timers_enable = req.wdata[t1cs_pkg::ALL_EN_BIT];
            // Writing one to the all-enable also starts both timers
            if (req.wdata[t1cs_pkg::ALL_EN_BIT]) begin
                ctrl_d.timer1_run_enable = 1'b1;                    // RULE_16
                t0set_d                  = 1'b1;                    // RULE_16
            end
            // Write one clears the flag
            if (req.wdata[t1cs_pkg::IRQ_FLAG_BIT]) begin
                ctrl_d.timer1_irq_flag = 1'b0;                      // RULE_06
            end
        end
        // A new event beats a clear in the same cycle
        if (flag_set) begin
            ctrl_d.timer1_irq_flag = 1'b1;                          // RULE_04
        end
    end

    // Capture storage: overwrite only when reload is on or nothing held
    always_comb begin
        capture_store = cap_fire && ctrl_q.timer1_capture_mode
                        && ctrl_q.timer1_run_enable
                        && (ctrl_q.timer1_auto_reload || !held_q);  // RULE_11
        held_d = held_q;
        if (capture_read) begin
            held_d = 1'b0;
        end
        // A store in the reading cycle leaves a fresh value held
        if (capture_store) begin
            held_d = 1'b1;
        end
    end

    // Generate mode stops at the terminal value without auto reload
    assign hold_at_terminal = !ctrl_q.timer1_capture_mode
                              && !ctrl_q.timer1_auto_reload;        // RULE_10

    // Pin and interrupt next values
    always_comb begin
        gen_d = gen_raw && ctrl_q.timer1_ext_generate_enable;       // RULE_13
        irq_d = ctrl_q.timer1_irq_flag && ctrl_q.timer1_irq_enable; // RULE_08
        pwm_d = pwm_q;
        // Timer 0 rollover opens the period, timer 1 ends the high time
        if (!ctrl_q.pwm_pair_enable) begin
            pwm_d = 1'b0;                                           // RULE_01
        end else if (t1_rollover) begin
            pwm_d = 1'b0;                                           // RULE_02
        end else if (t0_rollover) begin
            pwm_d = 1'b1;                                           // RULE_02
        end
    end

    // Read port: image captured on the request, valid one cycle later
    always_comb begin
        rvalid_d = req.rd_en;
        rdata_d  = rdata_q;
        if (req.rd_en) begin
            rdata_d = image(ctrl_q);
        end
    end

    // State registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q      <= '0;                                      // RULE_17
            rdata_q     <= 32'h0000_0000;
            rvalid_q    <= 1'b0;
            trig_s1_q   <= 1'b0;
            trig_s2_q   <= 1'b0;
            trig_prev_q <= 1'b0;
            gen_q       <= 1'b0;
            pwm_q       <= 1'b0;
            irq_q       <= 1'b0;
            t0set_q     <= 1'b0;
            held_q      <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            trig_s1_q   <= capture_trig;
            trig_s2_q   <= trig_s1_q;
            trig_prev_q <= trig_s2_q;
            gen_q       <= gen_d;
            pwm_q       <= pwm_d;
            irq_q       <= irq_d;
            t0set_q     <= t0set_d;
            held_q      <= held_d;
        end
    end

    // Outputs; the load field acts as a level while it is set
    assign ctrl           = ctrl_q;                                 // RULE_09
    assign rdata          = rdata_q;
    assign rvalid         = rvalid_q;
    assign gen_out        = gen_q;
    assign pwm_out        = pwm_q;
    assign irq            = irq_q;
    assign timer0_run_set = t0set_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_CAP_SETS: assert property ( // RULE_04
        cap_fire && ctrl_q.timer1_run_enable && ctrl_q.timer1_capture_mode
        |=> ctrl_q.timer1_irq_flag)
        else $error("capture did not set flag");

    AST_ROLL_SETS: assert property ( // RULE_05
        t1_rollover && !ctrl_q.timer1_capture_mode
        |=> ctrl_q.timer1_irq_flag)
        else $error("rollover did not set flag");

    AST_CLEAR: assert property ( // RULE_06
        wr_lo && req.wdata[t1cs_pkg::IRQ_FLAG_BIT] && !flag_set
        |=> !ctrl_q.timer1_irq_flag)
        else $error("write one did not clear flag");

    AST_KEEP: assert property ( // RULE_06
        ctrl_q.timer1_irq_flag
        && !(wr_lo && req.wdata[t1cs_pkg::IRQ_FLAG_BIT])
        |=> ctrl_q.timer1_irq_flag)
        else $error("flag lost without a clear");

    AST_IRQ_GATE: assert property ( // RULE_08
        ctrl_q.timer1_irq_flag && !ctrl_q.timer1_irq_enable
        && !req.wr_en ##1 !req.wr_en
        |=> !irq && ctrl_q.timer1_irq_flag)
        else $error("interrupt enable misgates");

    AST_ALL_SET: assert property ( // RULE_16
        wr_lo && req.wdata[t1cs_pkg::ALL_EN_BIT]
        |=> ctrl_q.timer1_run_enable && ctrl_q.all_timers_enable
            && timer0_run_set
            ##1 (!timer0_run_set
                 || $past(wr_lo && req.wdata[t1cs_pkg::ALL_EN_BIT])))
        else $error("all enable did not start timers");

    AST_ALL_ZERO: assert property ( // RULE_16
        wr_lo && !wr_hi && !req.wdata[t1cs_pkg::ALL_EN_BIT]
        && ctrl_q.timer1_run_enable
        |=> ctrl_q.timer1_run_enable && !ctrl_q.all_timers_enable)
        else $error("all enable zero touched run");

    AST_PWM_HIGH: assert property ( // RULE_02
        ctrl_q.pwm_pair_enable && t0_rollover && !t1_rollover
        |=> pwm_out)
        else $error("pwm did not rise on period start");

    AST_GEN_GATE: assert property ( // RULE_13
        !ctrl_q.timer1_ext_generate_enable |=> !gen_out)
        else $error("generate output not gated");

    AST_CAP_HOLD: assert property ( // RULE_11
        held_q && !ctrl_q.timer1_auto_reload |-> !capture_store)
        else $error("held capture overwritten");

    // Reset is the trigger here, so the default disable must not mask it
    AST_RESET: assert property (@(posedge clk) disable iff (1'b0) // RULE_17
        reset |=> ctrl_q == '0 && !irq && !pwm_out)
        else $error("reset left fields set");

    // PWM end of high time and forced low when the pair is off
    AST_PWM_LOW: assert property ( // RULE_02
        ctrl_q.pwm_pair_enable && t1_rollover |=> !pwm_out)
        else $error("pwm did not fall on high time end");

    AST_PWM_OFF: assert property ( // RULE_01
        !ctrl_q.pwm_pair_enable |=> !pwm_out)
        else $error("pwm active while disabled");

    // Interrupt follows the flag one cycle late when enabled
    AST_IRQ_ON: assert property ( // RULE_08
        ctrl_q.timer1_irq_flag && ctrl_q.timer1_irq_enable |=> irq)
        else $error("enabled flag gave no interrupt");

    // Run enable takes the written value when only lane 3 is written
    AST_RUN_WRITE: assert property ( // RULE_07
        wr_hi && !wr_lo
        |=> ctrl_q.timer1_run_enable == $past(req.wdata[t1cs_pkg::RUN_EN_BIT]))
        else $error("run enable write lost");

    // Direction and mode change only by a write
    AST_FIELD_KEEP: assert property ( // RULE_14
        !req.wr_en
        |=> $stable(ctrl_q.timer1_count_down)
            && $stable(ctrl_q.timer1_capture_mode))
        else $error("mode field moved without a write");

    // Reading the captured value frees the holding slot
    AST_HOLD_CLEAR: assert property ( // RULE_11
        capture_read && !capture_store |=> !held_q)
        else $error("held capture not released by read");

    // Rollover must not raise the flag in capture mode
    AST_ROLL_CAP: assert property ( // RULE_05
        t1_rollover && ctrl_q.timer1_capture_mode && !cap_fire
        && !ctrl_q.timer1_irq_flag
        |=> !ctrl_q.timer1_irq_flag)
        else $error("rollover set flag in capture mode");

    // Cover points for the main scenarios
    COV_CAPTURE: cover property (capture_store ##[1:20] rvalid);
    COV_PWM: cover property (pwm_out ##[1:50] !pwm_out);
    COV_RACE: cover property (flag_set && wr_lo
                              && req.wdata[t1cs_pkg::IRQ_FLAG_BIT]);
    COV_ALL_EN: cover property (timer0_run_set);
    COV_IRQ: cover property (irq ##1 !ctrl_q.timer1_irq_flag);

endmodule : t1cs_top

// *** hdl/t1cs_pkg.sv ***
// Constants, field layout and carrier types of the timer 1 control/status
// register. Assumes one clock domain and field positions as printed.
// Notes on behaviour
// RULE_01: Field 22 turns paired pulse width modulation on.
// RULE_02: Timer 0 sets period, timer 1 high time.
// RULE_03: Software sets generate mode, active-high outputs first.
// RULE_04: Enabled capture in capture mode sets flag.
// RULE_05: Counter rollover in generate mode sets flag.
// RULE_06: Writing one clears flag; zero leaves it.
// RULE_07: Field 24 runs the counter; zero halts.
// RULE_08: Field 25 gates only the interrupt output.
// RULE_09: Field 26 high keeps loading from reload value.
// RULE_10: Generate: reload and run, or hold terminal.
// RULE_11: Capture: overwrite, or keep until read.
// RULE_12: Field 28 gates the external capture trigger.
// RULE_13: Field 29 gates the external generate output.
// RULE_14: Field 30 selects up or down counting.
// RULE_15: Field 31 selects generate or capture mode.
// RULE_16: All-enable write one sets both run enables.
// RULE_17: Reset clears every control and status field.
package t1cs_pkg;

    // Field positions, numbered as the vector index of the register word
    localparam int unsigned ALL_EN_BIT   = 21;
    localparam int unsigned PWM_EN_BIT   = 22;
    localparam int unsigned IRQ_FLAG_BIT = 23;
    localparam int unsigned RUN_EN_BIT   = 24;
    localparam int unsigned IRQ_EN_BIT   = 25;
    localparam int unsigned LOAD_BIT     = 26;
    localparam int unsigned AUTO_RLD_BIT = 27;
    localparam int unsigned EXT_CAP_BIT  = 28;
    localparam int unsigned EXT_GEN_BIT  = 29;
    localparam int unsigned DOWN_BIT     = 30;
    localparam int unsigned CAP_MODE_BIT = 31;

    // Byte lanes that hold implemented fields
    localparam int unsigned LANE_HI = 3;  // Fields 24..31
    localparam int unsigned LANE_LO = 2;  // Fields 21..23

    // Reset image of the whole register
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // Control fields that steer the counter datapath
    typedef struct packed {
        logic timer1_capture_mode;
        logic timer1_count_down;
        logic timer1_ext_generate_enable;
        logic timer1_ext_capture_enable;
        logic timer1_auto_reload;
        logic timer1_load_strobe;
        logic timer1_irq_enable;
        logic timer1_run_enable;
        logic timer1_irq_flag;
        logic pwm_pair_enable;
        logic all_timers_enable;
    } t1cs_ctrl_s;

    // Register access port carrier
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [3:0]  be;
        logic [31:0] wdata;
    } t1cs_req_s;

endpackage : t1cs_pkg

// *** test/t1cs_cpu.sv ***
// Processor model that works the plain strobe register port.
// Assumes the bench calls its tasks; all changes land at falling edges.
`timescale 1ns/1ns
module t1cs_cpu (
    // Clock
    input  wire logic           clk,
    // Register port toward the block
    output t1cs_pkg::t1cs_req_s req,
    input  wire logic [31:0]    rdata,
    input  wire logic           rvalid
);
    // Idle port at time zero
    initial begin
        req = '0;
    end

    // One word write; data goes to its inverse once released so that
    // a stale value can never pass for a fresh one
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        req.wr_en = 1'b1;
        req.be    = be;
        req.wdata = d;
        @(negedge clk);
        req.wr_en = 1'b0;
        req.be    = 4'h0;
        req.wdata = ~d;
    endtask : wr

    // One word read; image and valid taken one cycle after the strobe
    task automatic rd(output logic [31:0] d, output logic v);
        @(negedge clk);
        req.rd_en = 1'b1;
        @(negedge clk);
        req.rd_en = 1'b0;
        d = rdata;
        v = rvalid;
    endtask : rd
endmodule : t1cs_cpu

// *** test/testbench.sv ***
// Self-checking bench for the timer 1 control/status block.
// Assumes the processor model drives the register port; events by bench.
`timescale 1ns/1ns
module testbench;
    // Clock, reset and datapath stimulus
    logic                 clk, reset, t1_rollover, t0_rollover, gen_raw;
    logic                 capture_read, capture_trig, rvalid, v;
    logic                 gen_out, pwm_out, capture_store;
    logic                 hold_at_terminal, timer0_run_set, irq;
    logic [31:0]          rdata, rd_v;
    t1cs_pkg::t1cs_req_s  req;
    t1cs_pkg::t1cs_ctrl_s ctrl;
    int                   failures, n_checks, cycles, hits;

    t1cs_top dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
        .rvalid(rvalid), .t1_rollover(t1_rollover),
        .t0_rollover(t0_rollover), .gen_raw(gen_raw),
        .capture_read(capture_read), .capture_trig(capture_trig),
        .gen_out(gen_out), .pwm_out(pwm_out), .ctrl(ctrl),
        .capture_store(capture_store), .hold_at_terminal(hold_at_terminal),
        .timer0_run_set(timer0_run_set), .irq(irq));
    t1cs_cpu u_cpu (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

    // Free running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard, far above the roughly 140 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            failures++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    // One-cycle pulse on {capture_read, t0_rollover, t1_rollover}
    task automatic ev(input logic [2:0] k);
        @(negedge clk);
        {capture_read, t0_rollover, t1_rollover} = k;
        @(negedge clk);
        {capture_read, t0_rollover, t1_rollover} = 3'h0;
    endtask : ev

    // Pin rise, then count store pulses over the sync delay
    task automatic trig(output int h);
        h = 0;
        @(negedge clk);
        capture_trig = 1'b1;
        repeat (6) begin
            @(negedge clk);
            if (capture_store === 1'b1) h++;
        end
        capture_trig = 1'b0;
        repeat (3) @(negedge clk);
    endtask : trig

    task automatic t_reset;
        u_cpu.rd(rd_v, v);
        chk(rd_v, 32'h0000_0000);
        chk(32'(ctrl), 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        chk(32'(v), 32'h0000_0001);
        chk(32'({pwm_out, gen_out, timer0_run_set}), 32'h0000_0000);
    endtask : t_reset

    // Control fields 22 and 24 to 31 alone; lanes 0 and 1 written but must read 0
    task automatic t_fields;
        for (int b = 22; b < 32; b++) begin
            if (b == 23) continue;
            u_cpu.wr(4'hf, 32'h0000_ffff | (32'h1 << b));
            chk(32'(ctrl), 32'h1 << (b - 21));
            chk(32'(hold_at_terminal), 32'(b != 27 && b != 31));
            u_cpu.rd(rd_v, v);
            chk(rd_v, 32'h1 << b);
            chk(32'(v), 32'h0000_0001);
        end
    endtask : t_fields

    task automatic t_flag;
        u_cpu.wr(4'hc, 32'h0180_0000);
        ev(3'h1);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0001);
        @(negedge clk);
        chk(32'(irq), 32'h0000_0000);
        u_cpu.wr(4'hc, 32'h0300_0000);
        @(negedge clk);
        chk(32'(irq), 32'h0000_0001);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0001);
        u_cpu.wr(4'hc, 32'h0380_0000);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0000);
    endtask : t_flag

    task automatic t_capture;
        u_cpu.wr(4'hc, 32'h8180_0000);
        ev(3'h1);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0000);
        trig(hits);
        chk(32'(hits), 32'h0000_0000);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0000);
        u_cpu.wr(4'hc, 32'h9100_0000);
        trig(hits);
        chk(32'(hits), 32'h0000_0001);
        chk(32'(ctrl.timer1_irq_flag), 32'h0000_0001);
        trig(hits);
        chk(32'(hits), 32'h0000_0000);
        ev(3'h4);
        trig(hits);
        chk(32'(hits), 32'h0000_0001);
        u_cpu.wr(4'hc, 32'h9900_0000);
        trig(hits);
        chk(32'(hits), 32'h0000_0001);
    endtask : t_capture

    task automatic t_gen;
        u_cpu.wr(4'hc, 32'h0080_0000);
        gen_raw = 1'b1;
        repeat (2) @(negedge clk);
        chk(32'(gen_out), 32'h0000_0000);
        u_cpu.wr(4'hc, 32'h2000_0000);
        @(negedge clk);
        chk(32'(gen_out), 32'h0000_0001);
        gen_raw = 1'b0;
    endtask : t_gen

    task automatic t_pwm;
        // Generate mode both timers, outputs taken as active high
        u_cpu.wr(4'hc, 32'h0040_0000);
        ev(3'h2);
        chk(32'(pwm_out), 32'h0000_0001);
        ev(3'h1);
        chk(32'(pwm_out), 32'h0000_0000);
        ev(3'h2);
        u_cpu.wr(4'hc, 32'h0000_0000);
        @(negedge clk);
        chk(32'(pwm_out), 32'h0000_0000);
    endtask : t_pwm

    task automatic t_all;
        // Also clears the flag left by the rollover of the PWM scenario
        u_cpu.wr(4'h4, 32'h00a0_0000);
        hits = 32'(timer0_run_set === 1'b1);
        chk(32'(ctrl), 32'h0000_0009);
        @(negedge clk);
        hits += 32'(timer0_run_set === 1'b1);
        chk(32'(hits), 32'h0000_0001);
        u_cpu.wr(4'h4, 32'h0000_0000);
        chk(32'(ctrl), 32'h0000_0008);
    endtask : t_all

    // Main sequence
    initial begin
        {reset, t1_rollover, t0_rollover, gen_raw} = 4'h8;
        {capture_read, capture_trig} = 2'h0;
        repeat (6) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_fields();
        t_flag();
        t_capture();
        t_gen();
        t_pwm();
        t_all();
        summarize();
    end
endmodule : testbench
